// ===== hw/ssa_advance.sv
// Ten-step sequencer advance logic with APB configuration
`include "ssa_defs.svh"

module ssa_advance
	import ssa_pkg::*;
#(
	parameter int TICK_CYCLES = `SSA_TICK_S * `SSA_CLK_HZ
) (
	input  wire logic            sys_clk_i,
	input  wire logic            rst_n_i,
	input  wire ssa_apb_req_type apb_i,
	output ssa_apb_rsp_type      apb_o,
	input  wire logic [4:0]      input_pins_i,
	input  wire logic [4:0]      key_pins_i,
	input  wire logic [13:0]     analog1_i,
	input  wire logic [13:0]     analog2_i,
	output logic [3:0]           step_o,
	output logic                 advance_o,
	output logic                 jump_o
);

	// ****************************************
	// Condition evaluation
	// ****************************************
	function automatic logic cond_hit(input logic [4:0] code, input logic [4:0] in_ev,
			input logic [4:0] key_ev, input logic a1l, input logic a1h, input logic a2l,
			input logic a2h, input logic tmo);
		logic hit;
		hit = 1'b0;
		case (ssa_cond_type'(code))
			SSA_IN6:            hit = in_ev[0];
			SSA_IN7:            hit = in_ev[1];
			SSA_IN8:            hit = in_ev[2];
			SSA_IN9:            hit = in_ev[3];
			SSA_IN10:           hit = in_ev[4];
			SSA_A1_LOW:         hit = a1l;
			SSA_A1_HIGH:        hit = a1h;
			SSA_A2_LOW:         hit = a2l;
			SSA_A2_HIGH:        hit = a2h;
			SSA_A1_WINDOW:      hit = a1l | a1h;
			SSA_IN10_OR_A1_LOW: hit = in_ev[4] | a1l;
			SSA_IN9_OR_A2_HIGH: hit = in_ev[3] | a2h;
			SSA_KEY1:           hit = key_ev[0];
			SSA_KEY2:           hit = key_ev[1];
			SSA_KEY3:           hit = key_ev[2];
			SSA_KEY4:           hit = key_ev[3];
			SSA_ENTER:          hit = key_ev[4];
			SSA_TIME:           hit = tmo;
			SSA_IN6_T:          hit = in_ev[0] | tmo;
			SSA_IN7_T:          hit = in_ev[1] | tmo;
			SSA_IN8_T:          hit = in_ev[2] | tmo;
			SSA_IN9_T:          hit = in_ev[3] | tmo;
			SSA_IN10_T:         hit = in_ev[4] | tmo;
			SSA_A1_LOW_T:       hit = a1l | tmo;
			SSA_A2_HIGH_T:      hit = a2h | tmo;
			SSA_KEY1_T:         hit = key_ev[0] | tmo;
			SSA_KEY2_T:         hit = key_ev[1] | tmo;
			default:            hit = 1'b0;
		endcase
		return hit;
	endfunction

	// ****************************************
	// State
	// ****************************************
	ssa_state_type    s;
	ssa_state_type    next_s;
	ssa_step_cfg_type cur;
	logic [4:0]       in_ev;
	logic [4:0]       key_ev;
	logic             a1l;
	logic             a1h;
	logic             a2l;
	logic             a2h;
	logic [21:0]      duration;
	logic             tmo;
	logic             tick;
	logic             next_hit;
	logic             jump_hit;
	logic             in_step_page;
	logic [3:0]       reg_idx;
	logic [1:0]       reg_sub;
	logic             mapped;
	logic [31:0]      rd_value;
	logic             wr_fire;
	logic [13:0]      wr_low;
	logic [13:0]      wr_high;
	logic [5:0]       wr_sec;

	always_comb begin
		cur = s.cfg[s.step];
		for (int i = 0; i < 5; i++) begin
			// Edge, not level, so a held switch advances only once
			in_ev[i]  = s.in_s2[i] & ~s.in_prev[i] & (s.in_func[i] == `SSA_FUNC_ADVANCE);
			key_ev[i] = s.key_s2[i] & ~s.key_prev[i] & (s.key_func[i] == `SSA_FUNC_ADVANCE);
		end
		a1l = analog1_i < cur.low_limit;
		a2l = analog2_i < cur.low_limit;
		a1h = analog1_i > cur.high_limit;
		a2h = analog2_i > cur.high_limit;
		duration = 22'(cur.minutes) * `SSA_SEC_PER_MIN + 22'(cur.seconds);
		tmo = s.elapsed >= duration;
		tick = s.tick_cnt == 28'(TICK_CYCLES - 1);
		next_hit = s.run & cond_hit(cur.next_sel, in_ev, key_ev, a1l, a1h, a2l, a2h, tmo);
		// Same decoder serves both selectors
		jump_hit = s.run & (cur.jump_target != 4'h0) & (cur.jump_target <= `SSA_STEPS)
			& cond_hit(cur.jump_sel, in_ev, key_ev, a1l, a1h, a2l, a2h, tmo);
	end

	// ****************************************
	// APB decode
	// ****************************************
	always_comb begin
		in_step_page = apb_i.paddr[11:8] == `SSA_STEP_PAGE;
		reg_idx = apb_i.paddr[7:4];
		reg_sub = apb_i.paddr[3:2];
		rd_value = 32'h0000_0000;
		mapped = 1'b1;
		if (apb_i.paddr[1:0] != 2'h0) begin
			mapped = 1'b0;
		end else if (apb_i.paddr == `SSA_CTRL_OFS) begin
			rd_value = {31'h0000_0000, s.run};
		end else if (apb_i.paddr == `SSA_INFUNC_OFS) begin
			rd_value = {12'h000, s.in_func};
		end else if (apb_i.paddr == `SSA_KEYFUNC_OFS) begin
			rd_value = {12'h000, s.key_func};
		end else if (apb_i.paddr == `SSA_STATUS_OFS) begin
			rd_value = {2'h0, s.elapsed, 4'h0, s.step + 4'h1};
		end else if (in_step_page && reg_idx < `SSA_STEPS && reg_sub == `SSA_COND_SUB) begin
			rd_value = {12'h000, s.cfg[reg_idx].jump_target, 3'h0, s.cfg[reg_idx].jump_sel,
				3'h0, s.cfg[reg_idx].next_sel};
		end else if (in_step_page && reg_idx < `SSA_STEPS && reg_sub == `SSA_TIME_SUB) begin
			rd_value = {s.cfg[reg_idx].minutes, 10'h000, s.cfg[reg_idx].seconds};
		end else if (in_step_page && reg_idx < `SSA_STEPS && reg_sub == `SSA_LIMIT_SUB) begin
			rd_value = {2'h0, s.cfg[reg_idx].high_limit, 2'h0, s.cfg[reg_idx].low_limit};
		end else begin
			mapped = 1'b0;
		end
		wr_fire = apb_i.psel & apb_i.penable & apb_i.pwrite & mapped;
		// Out-of-range limits and seconds are clamped rather than refused
		wr_low = apb_i.pwdata[`SSA_LOW_LSB +: 14];
		wr_high = apb_i.pwdata[`SSA_HIGH_LSB +: 14];
		wr_sec = apb_i.pwdata[`SSA_SEC_LSB +: 6];
		if (wr_low > `SSA_LIMIT_MAX) begin
			wr_low = `SSA_LIMIT_MAX;
		end
		if (wr_high > `SSA_LIMIT_MAX) begin
			wr_high = `SSA_LIMIT_MAX;
		end
		if (wr_sec > `SSA_SEC_MAX) begin
			wr_sec = `SSA_SEC_MAX;
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_s = s;
		next_s.in_s1 = input_pins_i;
		next_s.in_s2 = s.in_s1;
		next_s.in_prev = s.in_s2;
		next_s.key_s1 = key_pins_i;
		next_s.key_s2 = s.key_s1;
		next_s.key_prev = s.key_s2;
		next_s.advanced = 1'b0;
		next_s.jumped = 1'b0;

		// Read data is captured in the setup cycle so prdata comes from a flop
		if (apb_i.psel && !apb_i.penable) begin
			next_s.rdata = rd_value;
			next_s.slverr = ~mapped;
		end
		if (wr_fire) begin
			if (apb_i.paddr == `SSA_CTRL_OFS) begin
				next_s.run = apb_i.pwdata[0];
			end else if (apb_i.paddr == `SSA_INFUNC_OFS) begin
				next_s.in_func = apb_i.pwdata[19:0];
			end else if (apb_i.paddr == `SSA_KEYFUNC_OFS) begin
				next_s.key_func = apb_i.pwdata[19:0];
			end else if (in_step_page && reg_sub == `SSA_COND_SUB) begin
				next_s.cfg[reg_idx].next_sel = apb_i.pwdata[`SSA_NEXT_LSB +: 5];
				next_s.cfg[reg_idx].jump_sel = apb_i.pwdata[`SSA_JUMP_LSB +: 5];
				next_s.cfg[reg_idx].jump_target = apb_i.pwdata[`SSA_TARGET_LSB +: 4];
			end else if (in_step_page && reg_sub == `SSA_TIME_SUB) begin
				next_s.cfg[reg_idx].minutes = apb_i.pwdata[`SSA_MIN_LSB +: 16];
				next_s.cfg[reg_idx].seconds = wr_sec;
			end else if (in_step_page && reg_sub == `SSA_LIMIT_SUB) begin
				next_s.cfg[reg_idx].low_limit = wr_low;
				next_s.cfg[reg_idx].high_limit = wr_high;
			end
		end

		// One-second tick; elapsed saturates so a long step never wraps back to zero
		next_s.tick_cnt = tick ? 28'h000_0000 : s.tick_cnt + 28'h000_0001;
		if (tick && s.elapsed != 22'h3F_FFFF) begin
			next_s.elapsed = s.elapsed + 22'h00_0001;
		end

		if (!s.run) begin
			next_s.step = 4'h0;
			next_s.elapsed = 22'h00_0000;
			next_s.tick_cnt = 28'h000_0000;
		end else if (jump_hit) begin
			next_s.step = cur.jump_target - 4'h1;
			next_s.elapsed = 22'h00_0000;
			next_s.tick_cnt = 28'h000_0000;
			next_s.jumped = 1'b1;
		end else if (next_hit) begin
			next_s.step = (s.step == `SSA_STEPS - 4'h1) ? 4'h0 : s.step + 4'h1;
			next_s.elapsed = 22'h00_0000;
			next_s.tick_cnt = 28'h000_0000;
			next_s.advanced = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			s <= `SSA_STATE_RESET;
		end else begin
			s <= next_s;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign apb_o = '{prdata: s.rdata, pready: 1'b1, pslverr: s.slverr};
	assign step_o = s.step + 4'h1;
	assign advance_o = s.advanced;
	assign jump_o = s.jumped;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_next_disabled;
		s.run && !jump_hit && cur.next_sel == 5'(SSA_DISABLED) |=> $stable(s.step);
	endproperty
	a_next_disabled: assert property (p_next_disabled) else $error("disabled step moved");

	property p_next_step;
		s.run && next_hit && !jump_hit && s.step != 4'h9 |=> s.step == $past(s.step) + 4'h1;
	endproperty
	a_next_step: assert property (p_next_step) else $error("next step not taken");

	property p_wrap;
		s.run && next_hit && !jump_hit && s.step == 4'h9 ##1 1'b1 |-> s.step == 4'h0 && advance_o;
	endproperty
	a_wrap: assert property (p_wrap) else $error("step ten did not wrap");

	property p_jump;
		s.run && jump_hit |=> s.step == $past(cur.jump_target) - 4'h1 && jump_o && !advance_o;
	endproperty
	a_jump: assert property (p_jump) else $error("jump target missed");

	property p_no_target;
		s.run && (cur.jump_target == 4'h0 || cur.jump_target > `SSA_STEPS) |=> !jump_o;
	endproperty
	a_no_target: assert property (p_no_target) else $error("jump without target");

	property p_timer_restart;
		$changed(s.step) |-> s.elapsed == 22'h00_0000 ##1 s.elapsed <= 22'h00_0001;
	endproperty
	a_timer_restart: assert property (p_timer_restart) else $error("timer not restarted");

	property p_steps;
		s.step <= 4'h9;
	endproperty
	a_steps: assert property (p_steps) else $error("step index out of range");

	property p_input_gate;
		s.in_s2[4] && !s.in_prev[4] && s.in_func[4] != `SSA_FUNC_ADVANCE |-> !in_ev[4];
	endproperty
	a_input_gate: assert property (p_input_gate) else $error("ungated input counted");

	property p_analog_low;
		s.run && cur.next_sel == 5'(SSA_A1_LOW) && !jump_hit && analog1_i < cur.low_limit
			|=> advance_o;
	endproperty
	a_analog_low: assert property (p_analog_low) else $error("analog low missed");

	property p_limit_range;
		s.cfg[0].low_limit <= `SSA_LIMIT_MAX && s.cfg[0].high_limit <= `SSA_LIMIT_MAX;
	endproperty
	a_limit_range: assert property (p_limit_range) else $error("limit above full range");

	property p_analog_high;
		s.run && !jump_hit && cur.next_sel == 5'(SSA_A2_HIGH) && analog2_i > cur.high_limit
			|=> advance_o;
	endproperty
	a_analog_high: assert property (p_analog_high) else $error("analog high missed");

	property p_window;
		s.run && !jump_hit && cur.next_sel == 5'(SSA_A1_WINDOW) && analog1_i > cur.high_limit
			|=> advance_o;
	endproperty
	a_window: assert property (p_window) else $error("window high missed");

	property p_in10_or_low;
		s.run && !jump_hit && cur.next_sel == 5'(SSA_IN10_OR_A1_LOW)
			&& s.in_s2[4] && !s.in_prev[4] && s.in_func[4] == `SSA_FUNC_ADVANCE |=> advance_o;
	endproperty
	a_in10_or_low: assert property (p_in10_or_low) else $error("input ten missed");

	property p_in9_or_high;
		s.run && !jump_hit && cur.next_sel == 5'(SSA_IN9_OR_A2_HIGH)
			&& s.in_s2[3] && !s.in_prev[3] && s.in_func[3] == `SSA_FUNC_ADVANCE |=> advance_o;
	endproperty
	a_in9_or_high: assert property (p_in9_or_high) else $error("input nine missed");

	property p_enter;
		s.run && !jump_hit && cur.next_sel == 5'(SSA_ENTER)
			&& s.key_s2[4] && !s.key_prev[4] && s.key_func[4] == `SSA_FUNC_ADVANCE |=> advance_o;
	endproperty
	a_enter: assert property (p_enter) else $error("enter key missed");

	property p_timer_early;
		s.run && !jump_hit && cur.next_sel == 5'(SSA_TIME) && s.elapsed < 22'(cur.seconds)
			|=> !advance_o;
	endproperty
	a_timer_early: assert property (p_timer_early) else $error("timer fired early");

	property p_key_or_time;
		s.run && !jump_hit && cur.next_sel == 5'(SSA_KEY2_T)
			&& s.key_s2[1] && !s.key_prev[1] && s.key_func[1] == `SSA_FUNC_ADVANCE |=> advance_o;
	endproperty
	a_key_or_time: assert property (p_key_or_time) else $error("key two missed");

	property p_analog_or_time;
		s.run && !jump_hit && cur.next_sel == 5'(SSA_A1_LOW_T) && cur.minutes == 16'h0000
			&& cur.seconds == 6'h00 |=> advance_o;
	endproperty
	a_analog_or_time: assert property (p_analog_or_time) else $error("zero time missed");

	property p_jump_codes;
		s.run && cur.jump_sel == 5'(SSA_IN10_T) && cur.jump_target inside {[4'h1:`SSA_STEPS]}
			&& s.in_s2[4] && !s.in_prev[4] && s.in_func[4] == `SSA_FUNC_ADVANCE |=> jump_o;
	endproperty
	a_jump_codes: assert property (p_jump_codes) else $error("jump code missed");

	property p_key_jump;
		s.run && cur.jump_sel == 5'(SSA_KEY1) && cur.jump_target inside {[4'h1:`SSA_STEPS]}
			&& s.key_s2[0] && !s.key_prev[0] && s.key_func[0] == `SSA_FUNC_ADVANCE |=> jump_o;
	endproperty
	a_key_jump: assert property (p_key_jump) else $error("key one jump missed");

endmodule

// ===== hw/ssa_defs.svh
// Offsets, field positions, reset values and timing counts of the step advance block
// How it works
// - Disabled next-step selector never leaves the step
// - True next-step condition moves step n to n+1, step ten back to step one
// - Inputs six to ten count only when set to advance
// - Analog low true when input below low limit
// - Analog high true when input above high limit
// - Analog one window: below low or above high
// - Input ten or analog one low triggers
// - Input nine or analog two high triggers
// - Keys one to four count when set to advance
// - Enter key counts when set to advance
// - Timer fires after minutes plus seconds elapse
// - Input or timer, whichever comes first, triggers
// - Analog one low, analog two high, or timer
// - Key one or two, or timer, triggers
// - Jump condition moves directly to target step
// - Jump selector uses the same condition codes
// - Ten steps, each with its own settings
// - Disabled jump target never jumps; else steps 1-10
// - Limits are hundredths of percent, 0 to 100.00
`ifndef SSA_DEFS_SVH
`define SSA_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define SSA_CTRL_OFS      12'h000
`define SSA_INFUNC_OFS    12'h004
`define SSA_KEYFUNC_OFS   12'h008
`define SSA_STATUS_OFS    12'h00C
`define SSA_STEP_PAGE     4'h1
`define SSA_COND_SUB      2'h0
`define SSA_TIME_SUB      2'h1
`define SSA_LIMIT_SUB     2'h2

// ****************************************
// Field positions
// ****************************************
`define SSA_NEXT_LSB      0
`define SSA_JUMP_LSB      8
`define SSA_TARGET_LSB    16
`define SSA_SEC_LSB       0
`define SSA_MIN_LSB       16
`define SSA_LOW_LSB       0
`define SSA_HIGH_LSB      16
`define SSA_STAT_ELAPSED_LSB 8

// ****************************************
// Values and limits
// ****************************************
`define SSA_STEPS         4'hA
`define SSA_FUNC_ADVANCE  4'h1
`define SSA_LIMIT_MAX     14'h2710
`define SSA_SEC_MAX       6'h3C
`define SSA_SEC_PER_MIN   22'h00003C
`define SSA_STATE_RESET   '0

// ****************************************
// Timing
// ****************************************
`define SSA_TICK_S        1
`define SSA_CLK_HZ        200000000

`endif

// ===== hw/ssa_pkg.sv
// Types of the step advance block
package ssa_pkg;

	typedef enum logic [4:0] {
		SSA_DISABLED, SSA_IN6, SSA_IN7, SSA_IN8, SSA_IN9, SSA_IN10,
		SSA_A1_LOW, SSA_A1_HIGH, SSA_A2_LOW, SSA_A2_HIGH, SSA_A1_WINDOW,
		SSA_IN10_OR_A1_LOW, SSA_IN9_OR_A2_HIGH,
		SSA_KEY1, SSA_KEY2, SSA_KEY3, SSA_KEY4, SSA_ENTER, SSA_TIME,
		SSA_IN6_T, SSA_IN7_T, SSA_IN8_T, SSA_IN9_T, SSA_IN10_T,
		SSA_A1_LOW_T, SSA_A2_HIGH_T, SSA_KEY1_T, SSA_KEY2_T
	} ssa_cond_type;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} ssa_apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} ssa_apb_rsp_type;

	typedef struct packed {
		logic [4:0]  next_sel;
		logic [4:0]  jump_sel;
		logic [3:0]  jump_target;
		logic [15:0] minutes;
		logic [5:0]  seconds;
		logic [13:0] low_limit;
		logic [13:0] high_limit;
	} ssa_step_cfg_type;

	typedef struct packed {
		ssa_step_cfg_type [9:0] cfg;
		logic [4:0][3:0]        in_func;
		logic [4:0][3:0]        key_func;
		logic                   run;
		logic [3:0]             step;
		logic [21:0]            elapsed;
		logic [27:0]            tick_cnt;
		logic [4:0]             in_s1;
		logic [4:0]             in_s2;
		logic [4:0]             in_prev;
		logic [4:0]             key_s1;
		logic [4:0]             key_s2;
		logic [4:0]             key_prev;
		logic [31:0]            rdata;
		logic                   slverr;
		logic                   advanced;
		logic                   jumped;
	} ssa_state_type;

endpackage

// ===== test/ssa_field_model.sv
// Switches, keypad keys and analog sources on the far side of the step advance block
module ssa_field_model
	import ssa_pkg::*;
(
	input  wire logic        sys_clk_i,
	output logic [4:0]       input_pins_o,
	output logic [4:0]       key_pins_o,
	output logic [13:0]      analog1_o,
	output logic [13:0]      analog2_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// Idle levels
	// ****************************************
	initial begin
		input_pins_o = '0;
		key_pins_o = '0;
		analog1_o = 14'h1388;
		analog2_o = 14'h0000;
	end

	// ****************************************
	// Stimulus tasks
	// ****************************************
	// Pins stay low afterwards so the next press is a fresh edge
	task automatic press(input logic key, input int idx, input int hold);
		@(posedge sys_clk_i);
		if (key) begin
			key_pins_o[idx] <= 1'b1;
		end else begin
			input_pins_o[idx] <= 1'b1;
		end
		repeat (hold) @(posedge sys_clk_i);
		key_pins_o <= '0;
		input_pins_o <= '0;
		repeat (4) @(posedge sys_clk_i);
	endtask

	task automatic set_analog(input logic [13:0] v1, input logic [13:0] v2);
		@(posedge sys_clk_i);
		analog1_o <= v1;
		analog2_o <= v2;
	endtask
endmodule

// ===== test/testbench.sv
// Self-checking bench of the step advance block
module testbench
	import ssa_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic            sys_clk_i;
	logic            rst_n_i;
	ssa_apb_req_type req;
	ssa_apb_rsp_type rsp;
	logic [4:0]      pins;
	logic [4:0]      keys;
	logic [13:0]     a1;
	logic [13:0]     a2;
	logic [3:0]      step_o;
	logic            advance_o;
	logic            jump_o;
	logic [31:0]     rd;
	logic            err;
	int              mismatches;
	int              checked;

	ssa_advance #(.TICK_CYCLES(10)) ssa_advance_inst (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .apb_i(req), .apb_o(rsp),
		.input_pins_i(pins), .key_pins_i(keys), .analog1_i(a1), .analog2_i(a2),
		.step_o(step_o), .advance_o(advance_o), .jump_o(jump_o));

	ssa_field_model ssa_field_model_inst (
		.sys_clk_i(sys_clk_i), .input_pins_o(pins), .key_pins_o(keys),
		.analog1_o(a1), .analog2_o(a2));

	initial sys_clk_i = 1'b0;
	always #2.5 sys_clk_i = ~sys_clk_i;

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Bounded wait on pready; read data and error taken at that same edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk_i);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge sys_clk_i);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			give_verdict();
		end
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic cfg(input int s, input logic [3:0] sub, input logic [31:0] v);
		apb(1'b1, 12'(32'h100 + 16 * (s - 1) + 4 * sub), v);
	endtask

	task automatic cond(input int s, input ssa_cond_type nx, input ssa_cond_type jp,
			input logic [3:0] tgt);
		cfg(s, 4'h0, {12'h000, tgt, 3'h0, 5'(jp), 3'h0, 5'(nx)});
	endtask

	// Outputs are looked at on the falling edge, where they are settled
	task automatic wait_step(input logic [3:0] s, input int lim, input logic adv,
			input logic jmp);
		int n;
		n = 0;
		do begin
			@(negedge sys_clk_i);
			n++;
		end while (step_o !== s && n < lim);
		check("step", step_o, s);
		check("advance pulse", advance_o, adv);
		check("jump pulse", jump_o, jmp);
		if (step_o !== s) begin
			give_verdict();
		end
	endtask

	task automatic hold_step(input logic [3:0] s);
		repeat (12) @(negedge sys_clk_i);
		check("step held", step_o, s);
	endtask

	task automatic press_to(input logic key, input int idx, input logic [3:0] s,
			input logic adv, input logic jmp);
		fork
			ssa_field_model_inst.press(key, idx, 4);
			wait_step(s, 20, adv, jmp);
		join
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		check("step after reset", step_o, 4'h1);
		apb(1'b0, 12'h00C, 32'h0);
		check("status", rd, 32'h0000_0001);
		apb(1'b0, 12'hFFC, 32'h0);
		check("unmapped error", err, 1'b1);
		cfg(1, 4'h1, 32'h0000_003F);
		apb(1'b0, 12'h104, 32'h0);
		check("seconds clamp", rd, 32'h0000_003C);
		cfg(1, 4'h2, 32'h3FFF_3FFF);
		apb(1'b0, 12'h108, 32'h0);
		check("limit clamp", rd, 32'h2710_2710);
		apb(1'b1, 12'h004, 32'h0000_0001);
		apb(1'b1, 12'h008, 32'h0000_0001);
		apb(1'b1, 12'h000, 32'h0000_0001);
		$display("test reset done");
	endtask

	task automatic t_digital();
		cond(1, SSA_DISABLED, SSA_DISABLED, 4'h0);
		ssa_field_model_inst.press(1'b0, 0, 4);
		hold_step(4'h1);
		cond(1, SSA_IN6, SSA_DISABLED, 4'h0);
		apb(1'b1, 12'h004, 32'h0000_0002);
		ssa_field_model_inst.press(1'b0, 0, 4);
		hold_step(4'h1);
		apb(1'b1, 12'h004, 32'h0000_0001);
		cond(2, SSA_IN6, SSA_DISABLED, 4'h0);
		fork
			ssa_field_model_inst.press(1'b0, 0, 30);
			wait_step(4'h2, 20, 1'b1, 1'b0);
		join
		check("one advance per press", step_o, 4'h2);
		$display("test digital done");
	endtask

	task automatic t_analog();
		cond(2, SSA_A1_LOW, SSA_DISABLED, 4'h0);
		cfg(2, 4'h2, 32'h2328_0064);
		ssa_field_model_inst.set_analog(14'h0064, 14'h0000);
		hold_step(4'h2);
		cond(3, SSA_A2_HIGH, SSA_DISABLED, 4'h0);
		cfg(3, 4'h2, 32'h00C8_0000);
		ssa_field_model_inst.set_analog(14'h0063, 14'h00C9);
		wait_step(4'h3, 10, 1'b1, 1'b0);
		wait_step(4'h4, 10, 1'b1, 1'b0);
		cfg(4, 4'h2, 32'h2328_0064);
		ssa_field_model_inst.set_analog(14'h1388, 14'h0000);
		cond(4, SSA_A1_WINDOW, SSA_DISABLED, 4'h0);
		hold_step(4'h4);
		ssa_field_model_inst.set_analog(14'h2329, 14'h0000);
		wait_step(4'h5, 20, 1'b1, 1'b0);
		ssa_field_model_inst.set_analog(14'h1388, 14'h0000);
		$display("test analog done");
	endtask

	task automatic t_jump_timer();
		cond(5, SSA_KEY1, SSA_KEY1, 4'h9);
		cond(9, SSA_TIME, SSA_DISABLED, 4'h0);
		cfg(9, 4'h1, 32'h0000_0002);
		cond(10, SSA_TIME, SSA_DISABLED, 4'h0);
		fork
			ssa_field_model_inst.press(1'b1, 0, 4);
			wait_step(4'h9, 20, 1'b0, 1'b1);
		join_any
		repeat (20) @(negedge sys_clk_i);
		check("timer not yet out", step_o, 4'h9);
		wait_step(4'hA, 1, 1'b1, 1'b0);
		wait_step(4'h1, 5, 1'b1, 1'b0);
		$display("test jump and timer done");
	endtask

	task automatic t_codes();
		apb(1'b1, 12'h004, 32'h0001_1001);
		apb(1'b1, 12'h008, 32'h0001_0011);
		cond(2, SSA_IN10_OR_A1_LOW, SSA_DISABLED, 4'h0);
		cond(3, SSA_IN9_OR_A2_HIGH, SSA_DISABLED, 4'h0);
		cond(4, SSA_KEY2_T, SSA_DISABLED, 4'h0);
		cfg(4, 4'h1, 32'h0001_0000);
		cond(5, SSA_DISABLED, SSA_IN10_T, 4'h2);
		cfg(5, 4'h1, 32'h0001_0000);
		cond(1, SSA_ENTER, SSA_DISABLED, 4'h0);
		press_to(1'b1, 4, 4'h2, 1'b1, 1'b0);
		press_to(1'b0, 4, 4'h3, 1'b1, 1'b0);
		cond(2, SSA_A1_LOW_T, SSA_DISABLED, 4'h0);
		press_to(1'b0, 3, 4'h4, 1'b1, 1'b0);
		press_to(1'b1, 1, 4'h5, 1'b1, 1'b0);
		fork
			ssa_field_model_inst.press(1'b0, 4, 4);
			begin
				wait_step(4'h2, 20, 1'b0, 1'b1);
				wait_step(4'h3, 5, 1'b1, 1'b0);
			end
		join
		$display("test codes done");
	endtask

	initial begin
		req = '0;
		rst_n_i = 1'b0;
		mismatches = 0;
		checked = 0;
		repeat (4) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_digital();
		t_analog();
		t_jump_timer();
		t_codes();
		give_verdict();
	end
endmodule
